// ==== occ_pkg.sv ====
// Package for the oscillator control register block
//
// Summary of operation
// - All oscillator registers reset only on power-on reset, not other resets.
// - Current source field, bits 14-12, read-only, reports active clock source.
// - New source field, bits 10-8, writable, holds requested switch target.
// - Current and new source load from initial source config at power-on.
// - In switching mode 01, switch lock bit is set-only and blocks switching.
// - Pin-select lock bit set blocks writes to pin select registers.
// - PLL lock bit reads 1 when locked or start timer expired, only while PLL in use.
// - Clock-fail flag set by monitor, cleared only by software.
// - Secondary oscillator enable bit drives oscillator on or off, resets 0.
// - Switch request bit set by software, cleared by device on completion.
// - Control register writes accepted only after unlock sequence.
// - Recover-on-interrupt set makes any interrupt clear reduction enable.
// - Reduction ratio divides instruction clock by 2^field, resets to 011.
// - Reduction enable applies ratio; clear forces 1:1; resets 0.
// - Fast RC postscaler divides by 1..64 then 256, resets 000.
// - PLL output divider 00/01/11 gives 2/4/8, 10 reserved, resets 01.
// - PLL feedback field gives multiplier value plus two, resets to 48 (multiplier 50).
// - Fast RC tuning adjusts fast RC frequency about plus or minus 12 percent.
// - Switching mode 1x disables switch and monitor; 01 switch only; 00 both.
package occ_pkg;
    localparam logic [3:0] OCC_ADDR_CTRL = 4'h0;
    localparam logic [3:0] OCC_ADDR_DIV = 4'h1;
    localparam logic [3:0] OCC_ADDR_FBD = 4'h2;
    localparam logic [3:0] OCC_ADDR_TUN = 4'h3;
    localparam logic [3:0] OCC_ADDR_AUX = 4'h4;
    localparam logic [3:0] OCC_ADDR_KEY = 4'h5;
    localparam logic [3:0] OCC_ADDR_PPS = 4'h6;

    localparam int OCC_CUR_LSB = 12;
    localparam int OCC_NEW_LSB = 8;
    localparam int OCC_SWLOCK_BIT = 7;
    localparam int OCC_PINLOCK_BIT = 6;
    localparam int OCC_PLLLOCK_BIT = 5;
    localparam int OCC_FAIL_BIT = 3;
    localparam int OCC_SECEN_BIT = 1;
    localparam int OCC_SWREQ_BIT = 0;
    localparam int OCC_ROI_BIT = 15;
    localparam int OCC_RATIO_LSB = 12;
    localparam int OCC_REDEN_BIT = 11;
    localparam int OCC_FAST_RC_POSTSCALER_LSB = 8;
    localparam int OCC_POST_LSB = 6;
    localparam int OCC_PRE_LSB = 0;

    localparam logic [2:0] OCC_RATIO_RST = 3'h3;
    localparam logic [2:0] OCC_FAST_RC_POSTSCALER_RST = 3'h0;
    localparam logic [1:0] OCC_POST_RST = 2'h1;
    localparam logic [1:0] OCC_POST_RSVD = 2'h2;
    localparam logic [8:0] OCC_FBD_RST = 9'h030;
    localparam logic [1:0] OCC_MODE_SW_ONLY = 2'h1;
    localparam logic [15:0] OCC_KEY1_DEF = 16'h0046;
    localparam logic [15:0] OCC_KEY2_DEF = 16'h0057;
    localparam int OCC_PLL_START_CYC = 64;
    localparam int OCC_RATIO_W = 3;

    typedef enum logic [1:0] {
        OCC_UL_IDLE = 2'b00,
        OCC_UL_KEY1 = 2'b01,
        OCC_UL_OPEN = 2'b11
    } occ_unlock_e;

    typedef struct packed {
        logic [2:0] frc_post;
        logic [1:0] pll_post;
        logic [4:0] pll_pre;
        logic [8:0] pll_mult_field;
        logic [5:0] frc_tune;
        logic sec_osc_en;
    } occ_clkcfg_s;
endpackage

// ==== occ_reduce_div.sv ====
// Peripheral clock reduction divider producing an enable pulse
`timescale 1ns/1ns
module occ_reduce_div
    import occ_pkg::*;
#(
    parameter int RW = OCC_RATIO_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cy_en,
    input wire logic [RW-1:0] ratio,
    input wire logic red_en,
    output logic periph_en
);
    logic [7:0] cnt_q;
    logic [7:0] limit;

    // Ratio forced to 1:1 when reduction is off
    assign limit = red_en ? 8'((9'h001 << ratio) - 9'h001) : 8'h00;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
        end else if (cy_en) begin
            cnt_q <= (cnt_q >= limit) ? 8'h00 : cnt_q + 8'h01;
        end
    end

    assign periph_en = cy_en && (cnt_q >= limit);

    a_ratio_one: assert property (@(posedge clk) disable iff (!rst_n)
        !red_en && cy_en |-> periph_en)
        else $error("reduction off but peripheral enable missed");
endmodule

// ==== occ_osc_ctrl.sv ====
// Oscillator control register block with Avalon-MM slave
`timescale 1ns/1ns
module occ_osc_ctrl
    import occ_pkg::*;
#(
    parameter logic [15:0] KEY1 = OCC_KEY1_DEF,
    parameter logic [15:0] KEY2 = OCC_KEY2_DEF,
    parameter int PLL_START_CYC = OCC_PLL_START_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [2:0] initial_source_config,
    input wire logic [1:0] switching_mode_config,
    input wire logic [7:0] source_ready,
    input wire logic pll_locked,
    input wire logic clock_failure,
    input wire logic irq_any,
    input wire logic cy_en,
    output logic [2:0] cur_source,
    output logic fail_safe_monitor_en,
    output occ_clkcfg_s clk_cfg,
    output logic periph_en,
    output logic [15:0] pps_reg,
    output logic [13:0] aux_clk_cfg
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [2:0] cur_q;
    logic [2:0] new_q;
    logic swlock_q;
    logic pinlock_q;
    logic fail_q;
    logic secen_q;
    logic swreq_q;
    logic roi_q;
    logic [2:0] ratio_q;
    logic reden_q;
    logic [2:0] fast_rc_postscaler_q;
    logic [1:0] post_q;
    logic [4:0] pre_q;
    logic [8:0] fbd_q;
    logic [5:0] tun_q;
    logic [13:0] aux_q;
    logic [15:0] pps_q;
    logic por_load_q;
    logic [7:0] pll_tmr_q;
    logic pll_ok;
    logic pll_on;
    logic ack_q;
    logic [31:0] rdata_q;
    logic wr_go;
    logic lo_be;
    logic [15:0] wd;
    logic ctrl_wr;
    logic sw_allowed;
    logic monitor_on;
    occ_unlock_e ul_q;

    // Power-on reset only: no other reset source reaches these flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // One-cycle acknowledge: waitrequest low the cycle after a request
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    // Writes land at the edge that samples waitrequest low, never earlier
    assign wr_go = avs_write && ack_q;
    assign lo_be = avs_byteenable[0] && avs_byteenable[1];
    assign wd = avs_writedata[15:0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
        end
    end

    // Unlock: KEY1 then KEY2 back to back, then one write is honoured
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ul_q <= OCC_UL_IDLE;
        end else if (wr_go) begin
            unique case (ul_q)
                OCC_UL_IDLE: begin
                    ul_q <= (avs_address == OCC_ADDR_KEY && wd == KEY1) ? OCC_UL_KEY1
                            : OCC_UL_IDLE;
                end
                OCC_UL_KEY1: begin
                    ul_q <= (avs_address == OCC_ADDR_KEY && wd == KEY2) ? OCC_UL_OPEN
                            : OCC_UL_IDLE;
                end
                OCC_UL_OPEN: begin
                    ul_q <= OCC_UL_IDLE;
                end
                default: begin
                    ul_q <= OCC_UL_IDLE;
                end
            endcase
        end else if (ul_q == OCC_UL_OPEN && !avs_write) begin
            // A write already on the bus keeps the window until its completing edge
            ul_q <= OCC_UL_IDLE;
        end
    end

    assign ctrl_wr = wr_go && lo_be && avs_address == OCC_ADDR_CTRL && ul_q == OCC_UL_OPEN;

    assign monitor_on = (switching_mode_config == 2'b00);
    assign sw_allowed = !switching_mode_config[1] && !swlock_q;
    assign fail_safe_monitor_en = monitor_on;

    // Strap is caught one clock after reset release, never inside the reset branch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            por_load_q <= 1'b1;
        end else begin
            por_load_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_q <= 3'h0;
        end else if (por_load_q) begin
            cur_q <= initial_source_config;
        end else if (swreq_q && source_ready[new_q] && sw_allowed) begin
            cur_q <= new_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            new_q <= 3'h0;
        end else if (por_load_q) begin
            new_q <= initial_source_config;
        end else if (ctrl_wr) begin
            new_q <= wd[OCC_NEW_LSB +: 3];
        end
    end

    // Request clears in the same cycle the current source updates
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            swreq_q <= 1'b0;
        end else if (swreq_q && source_ready[new_q] && sw_allowed) begin
            swreq_q <= 1'b0;
        end else if (ctrl_wr && wd[OCC_SWREQ_BIT]) begin
            swreq_q <= 1'b1;
        end
    end

    // Switch lock is set-only and can be set only while mode is 01; once set, only reset clears it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            swlock_q <= 1'b0;
        end else if (switching_mode_config == OCC_MODE_SW_ONLY && ctrl_wr
                     && wd[OCC_SWLOCK_BIT]) begin
            swlock_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinlock_q <= 1'b0;
            secen_q <= 1'b0;
        end else if (ctrl_wr) begin
            pinlock_q <= wd[OCC_PINLOCK_BIT];
            secen_q <= wd[OCC_SECEN_BIT];
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fail_q <= 1'b0;
        end else if (clock_failure && monitor_on) begin
            fail_q <= 1'b1;
        end else if (ctrl_wr && !wd[OCC_FAIL_BIT]) begin
            fail_q <= 1'b0;
        end
    end

    // PLL lock: locked input or start-up timer expiry, only while PLL in use
    assign pll_on = (cur_q == 3'h1) || (cur_q == 3'h3);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_tmr_q <= 8'h00;
        end else if (!pll_on) begin
            pll_tmr_q <= 8'h00;
        end else if (pll_tmr_q < 8'(PLL_START_CYC)) begin
            pll_tmr_q <= pll_tmr_q + 8'h01;
        end
    end
    assign pll_ok = pll_on && (pll_locked || pll_tmr_q >= 8'(PLL_START_CYC));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pps_q <= 16'h0000;
        end else if (wr_go && lo_be && avs_address == OCC_ADDR_PPS && !pinlock_q) begin
            pps_q <= wd;
        end
    end

    // Divisor register; interrupt recovery overrides a concurrent write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            roi_q <= 1'b0;
            ratio_q <= OCC_RATIO_RST;
            fast_rc_postscaler_q <= OCC_FAST_RC_POSTSCALER_RST;
            post_q <= OCC_POST_RST;
            pre_q <= 5'h00;
        end else if (wr_go && lo_be && avs_address == OCC_ADDR_DIV) begin
            roi_q <= wd[OCC_ROI_BIT];
            ratio_q <= wd[OCC_RATIO_LSB +: 3];
            fast_rc_postscaler_q <= wd[OCC_FAST_RC_POSTSCALER_LSB +: 3];
            // Reserved divider code is refused; previous value kept
            if (wd[OCC_POST_LSB +: 2] != OCC_POST_RSVD) begin
                post_q <= wd[OCC_POST_LSB +: 2];
            end
            pre_q <= wd[OCC_PRE_LSB +: 5];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reden_q <= 1'b0;
        end else if (irq_any && roi_q) begin
            reden_q <= 1'b0;
        end else if (wr_go && lo_be && avs_address == OCC_ADDR_DIV) begin
            reden_q <= wd[OCC_REDEN_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fbd_q <= OCC_FBD_RST;
            tun_q <= 6'h00;
            aux_q <= 14'h0000;
        end else if (wr_go && lo_be) begin
            if (avs_address == OCC_ADDR_FBD) begin
                fbd_q <= wd[8:0];
            end
            if (avs_address == OCC_ADDR_TUN) begin
                tun_q <= wd[5:0];
            end
            if (avs_address == OCC_ADDR_AUX) begin
                aux_q <= {wd[13:8], wd[7], 7'h00};
            end
        end
    end

    // Read data registered at the first edge of a request, one before the accepting edge; unmapped reads return zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            unique case (avs_address)
                OCC_ADDR_CTRL: rdata_q <= {16'h0000, 1'b0, cur_q, 1'b0, new_q, swlock_q,
                                           pinlock_q, pll_ok, 1'b0, fail_q, 1'b0,
                                           secen_q, swreq_q};
                OCC_ADDR_DIV: rdata_q <= {16'h0000, roi_q, ratio_q, reden_q, fast_rc_postscaler_q,
                                          post_q, 1'b0, pre_q};
                OCC_ADDR_FBD: rdata_q <= {23'h000000, fbd_q};
                OCC_ADDR_TUN: rdata_q <= {26'h0000000, tun_q};
                OCC_ADDR_AUX: rdata_q <= {18'h00000, aux_q};
                OCC_ADDR_PPS: rdata_q <= {16'h0000, pps_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end
    assign avs_readdata = rdata_q;

    occ_reduce_div #(.RW(OCC_RATIO_W)) u_div (
        .clk(clk),
        .rst_n(rst_n),
        .cy_en(cy_en),
        .ratio(ratio_q),
        .red_en(reden_q),
        .periph_en(periph_en)
    );

    assign cur_source = cur_q;
    assign pps_reg = pps_q;
    assign aux_clk_cfg = aux_q;
    assign clk_cfg = '{frc_post: fast_rc_postscaler_q, pll_post: post_q, pll_pre: pre_q,
                       pll_mult_field: fbd_q, frc_tune: tun_q, sec_osc_en: secen_q};

    a_lock_blocks: assert property (@(posedge clk) disable iff (!rst_n)
        swlock_q && !por_load_q |=> $stable(cur_q))
        else $error("current source changed while switch locked");
    a_lock_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        swlock_q |=> swlock_q)
        else $error("switch lock cleared");
    a_switch_done: assert property (@(posedge clk) disable iff (!rst_n)
        swreq_q && source_ready[new_q] && sw_allowed && !por_load_q
        |=> !swreq_q && cur_q == $past(new_q))
        else $error("switch did not complete with request clear");
    a_no_unlock: assert property (@(posedge clk) disable iff (!rst_n)
        wr_go && avs_address == OCC_ADDR_CTRL && ul_q != OCC_UL_OPEN && !por_load_q
        |=> $stable(new_q))
        else $error("control write accepted without unlock");
    a_fail_set: assert property (@(posedge clk) disable iff (!rst_n)
        clock_failure && monitor_on |=> fail_q)
        else $error("clock fail flag not set");
    a_pps_lock: assert property (@(posedge clk) disable iff (!rst_n)
        pinlock_q && !ctrl_wr |=> $stable(pps_q))
        else $error("pin select changed while locked");
    a_roi_clear: assert property (@(posedge clk) disable iff (!rst_n)
        irq_any && roi_q |=> !reden_q)
        else $error("interrupt did not clear reduction enable");
    a_pll_status: assert property (@(posedge clk) disable iff (!rst_n)
        !pll_on |-> !pll_ok)
        else $error("pll lock reported while disabled");
    a_post_rsvd: assert property (@(posedge clk) disable iff (!rst_n)
        post_q != OCC_POST_RSVD)
        else $error("reserved pll divider code stored");
    a_ack_one: assert property (@(posedge clk) disable iff (!rst_n)
        (avs_read || avs_write) && !ack_q |=> !avs_waitrequest || !(avs_read || avs_write))
        else $error("bus answer late");
endmodule

// ==== occ_osc_ctrl_tb_top.sv ====
// Self-checking testbench for the oscillator control register block
`timescale 1ns/1ns
module occ_osc_ctrl_tb_top import occ_pkg::*; ;
    logic clk;
    logic rstn;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [2:0] initial_source_config;
    logic [1:0] switching_mode_config;
    logic [7:0] source_ready;
    logic pll_locked;
    logic clock_failure;
    logic irq_any;
    logic cy_en;
    logic [2:0] cur_source;
    logic fail_safe_monitor_en;
    occ_clkcfg_s clk_cfg;
    logic periph_en;
    logic [15:0] pps_reg;
    logic [13:0] aux_clk_cfg;
    logic [31:0] rd;
    int n_fail;
    int tests_run;

    occ_osc_ctrl #(.PLL_START_CYC(8)) i_occ_osc_ctrl (
        .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .initial_source_config(initial_source_config),
        .switching_mode_config(switching_mode_config), .source_ready(source_ready),
        .pll_locked(pll_locked), .clock_failure(clock_failure), .irq_any(irq_any),
        .cy_en(cy_en), .cur_source(cur_source), .fail_safe_monitor_en(fail_safe_monitor_en),
        .clk_cfg(clk_cfg), .periph_en(periph_en), .pps_reg(pps_reg), .aux_clk_cfg(aux_clk_cfg)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Request stays up until the edge that sees waitrequest low
    task automatic ack_wait();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        chk({31'h0, avs_waitrequest}, 32'h0);
    endtask

    // No release here, so back-to-back writes keep write high without a gap
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        avs_read <= 1'b0;
        avs_write <= 1'b1;
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        ack_wait();
    endtask

    task automatic bus_idle();
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus_wr(a, d);
        bus_idle();
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        avs_write <= 1'b0;
        avs_read <= 1'b1;
        avs_address <= a;
        ack_wait();
        rd = avs_readdata;
        bus_idle();
        chk(rd & m, e);
    endtask

    // Keys and the control write go out with no idle cycle between them
    task automatic unl(input logic [15:0] d);
        bus_wr(OCC_ADDR_KEY, OCC_KEY1_DEF);
        bus_wr(OCC_ADDR_KEY, OCC_KEY2_DEF);
        bus_wr(OCC_ADDR_CTRL, d);
        bus_idle();
    endtask

    task automatic t_reset();
        chk({29'h0, cur_source}, 32'h7);
        rdchk(OCC_ADDR_CTRL, 32'hFFDF, 32'h7700);
        rdchk(OCC_ADDR_DIV, 32'hFFFFFFFF, 32'h3040);
        rdchk(OCC_ADDR_FBD, 32'hFFFFFFFF, 32'h0030);
        rdchk(OCC_ADDR_TUN, 32'hFFFFFFFF, 32'h0);
        rdchk(4'hF, 32'hFFFFFFFF, 32'h0);
        chk({18'h0, aux_clk_cfg}, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_switch();
        int n;
        unl(16'h5203);
        rdchk(OCC_ADDR_CTRL, 32'hFFDF, 32'h7203);
        chk({29'h0, cur_source}, 32'h7);
        source_ready <= 8'h84;
        n = 0;
        while (cur_source !== 3'h2 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk({29'h0, cur_source}, 32'h2);
        rdchk(OCC_ADDR_CTRL, 32'hFFDF, 32'h2202);
        chk({31'h0, clk_cfg.sec_osc_en}, 32'h1);
        wr(OCC_ADDR_CTRL, 16'h0000);
        rdchk(OCC_ADDR_CTRL, 32'hFFDF, 32'h2202);
        $display("test switch done");
    endtask

    task automatic t_fail();
        chk({31'h0, fail_safe_monitor_en}, 32'h1);
        clock_failure <= 1'b1;
        cyc(1);
        clock_failure <= 1'b0;
        cyc(2);
        rdchk(OCC_ADDR_CTRL, 32'hFFDF, 32'h220A);
        unl(16'h0202);
        rdchk(OCC_ADDR_CTRL, 32'hFFDF, 32'h2202);
        $display("test fail flag done");
    endtask

    task automatic t_pps();
        wr(OCC_ADDR_PPS, 16'h1234);
        chk({16'h0, pps_reg}, 32'h1234);
        unl(16'h0242);
        wr(OCC_ADDR_PPS, 16'h5678);
        chk({16'h0, pps_reg}, 32'h1234);
        rdchk(OCC_ADDR_CTRL, 32'hFFDF, 32'h2242);
        unl(16'h0202);
        wr(OCC_ADDR_PPS, 16'h5678);
        chk({16'h0, pps_reg}, 32'h5678);
        $display("test pin lock done");
    endtask

    task automatic t_div();
        wr(OCC_ADDR_DIV, 16'h2DE5);
        rdchk(OCC_ADDR_DIV, 32'hFFFFFFFF, 32'h2DC5);
        chk({29'h0, clk_cfg.frc_post}, 32'h5);
        chk({30'h0, clk_cfg.pll_post}, 32'h3);
        chk({27'h0, clk_cfg.pll_pre}, 32'h5);
        wr(OCC_ADDR_DIV, 16'h2D85);
        chk({30'h0, clk_cfg.pll_post}, 32'h3);
        irq_any <= 1'b1;
        cyc(1);
        irq_any <= 1'b0;
        cyc(1);
        rdchk(OCC_ADDR_DIV, 32'hFFFFFFFF, 32'h2DC5);
        wr(OCC_ADDR_DIV, 16'hADC5);
        irq_any <= 1'b1;
        cyc(1);
        irq_any <= 1'b0;
        cyc(1);
        rdchk(OCC_ADDR_DIV, 32'hFFFFFFFF, 32'hA5C5);
        $display("test divisor done");
    endtask

    // Windows of 256 cycles hold whole periods, so the divider phase does not matter
    task automatic t_doze();
        logic [2:0] rat [4];
        logic en;
        int cnt;
        rat = '{3'h0, 3'h2, 3'h7, 3'h5};
        for (int i = 0; i < 4; i++) begin
            en = (i < 3);
            wr(OCC_ADDR_DIV, {1'b0, rat[i], en, 11'h040});
            cnt = 0;
            repeat (256) begin
                @(posedge clk);
                if (periph_en === 1'b1) cnt++;
            end
            chk(cnt, en ? (32'h100 >> rat[i]) : 32'h100);
        end
        $display("test reduction done");
    endtask

    task automatic t_fbd();
        wr(OCC_ADDR_FBD, 16'hFFFF);
        rdchk(OCC_ADDR_FBD, 32'hFFFFFFFF, 32'h01FF);
        chk({23'h0, clk_cfg.pll_mult_field}, 32'h1FF);
        wr(OCC_ADDR_TUN, 16'hFFFF);
        rdchk(OCC_ADDR_TUN, 32'hFFFFFFFF, 32'h003F);
        chk({26'h0, clk_cfg.frc_tune}, 32'h3F);
        avs_byteenable <= 4'hC;
        wr(OCC_ADDR_FBD, 16'h0030);
        avs_byteenable <= 4'hF;
        rdchk(OCC_ADDR_FBD, 32'hFFFFFFFF, 32'h01FF);
        // PLL source: lock bit low while the start-up timer runs, high once it expires
        source_ready <= 8'h8C;
        unl(16'h0303);
        rdchk(OCC_ADDR_CTRL, 32'hF020, 32'h3000);
        cyc(10);
        rdchk(OCC_ADDR_CTRL, 32'hF020, 32'h3020);
        unl(16'h0203);
        pll_locked <= 1'b1;
        cyc(2);
        rdchk(OCC_ADDR_CTRL, 32'hF020, 32'h2000);
        unl(16'h0303);
        rdchk(OCC_ADDR_CTRL, 32'hF020, 32'h3020);
        unl(16'h0203);
        $display("test pll fields done");
    endtask

    task automatic t_lock();
        switching_mode_config <= 2'b10;
        source_ready <= 8'hFF;
        cyc(1);
        chk({31'h0, fail_safe_monitor_en}, 32'h0);
        unl(16'h0503);
        cyc(10);
        chk({29'h0, cur_source}, 32'h2);
        // The blocked request stays pending and completes once switching is enabled
        switching_mode_config <= 2'b01;
        cyc(2);
        chk({31'h0, fail_safe_monitor_en}, 32'h0);
        chk({29'h0, cur_source}, 32'h5);
        unl(16'h0282);
        rdchk(OCC_ADDR_CTRL, 32'h0080, 32'h0080);
        unl(16'h0203);
        cyc(10);
        chk({29'h0, cur_source}, 32'h5);
        rdchk(OCC_ADDR_CTRL, 32'h0080, 32'h0080);
        $display("test switch lock done");
    endtask

    initial begin
        n_fail = 0;
        tests_run = 0;
        rstn = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        initial_source_config = 3'h7;
        switching_mode_config = 2'b00;
        source_ready = 8'h80;
        pll_locked = 1'b0;
        clock_failure = 1'b0;
        irq_any = 1'b0;
        cy_en = 1'b1;
        cyc(16);
        rstn <= 1'b1;
        cyc(8);
        t_reset();
        t_switch();
        t_fail();
        t_pps();
        t_div();
        t_doze();
        t_fbd();
        t_lock();
        end_sim();
    end

    // Whole run is about 1300 cycles; the 20000-cycle limit leaves ample margin
    initial begin
        #2000000;
        n_fail++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end_sim();
    end
endmodule
